// ===== design/fsb_ctl.sv
// Bus agent control logic: parity, initialization, stall, sense and monitor outputs.
// What this block does
// - Parity line low on odd count lows.
// - All-high covered group gives high parity.
// - Launch and sample on the bus clock.
// - Assert reinit on unrecoverable bus condition.
// - Reinit resets lock and arbitration machines.
// - Reinit keeps in-order queue state intact.
// - After reinit, re-arbitrate and finish queues.
// - No new transaction while stall asserted.
// - Refuse operation while platform sense low.
// - Drive six breakpoint monitor status outputs.
// - Monitor line four gives probe ready.
// - Strobe starts parity check of request.
`timescale 1ns/1ps
`include "fsb_ctl_map.svh"
module fsb_ctl #(
    parameter int IOQ_DEPTH = 8
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        cfg_init_drive_en_i,
    input  wire logic        cfg_init_observe_en_i,
    input  wire logic        platform_sense_i,
    input  wire logic        bus_fault_i,
    input  wire logic        issue_req_i,
    input  wire logic [32:0] issue_addr_i,
    input  wire logic [4:0]  issue_type_i,
    input  wire logic        lock_req_i,
    input  wire logic        complete_i,
    input  wire logic [5:0]  monitor_event_i,
    input  wire logic        debug_ready_i,
    input  wire logic        address_valid_strobe_n_i,
    input  wire logic [32:0] bus_addr_n_i,
    input  wire logic [4:0]  bus_req_n_i,
    input  wire logic [1:0]  request_parity_lines_n_i,
    input  wire logic        bus_error_reinit_n_i,
    input  wire logic        new_request_stall_n_i,
    input  wire logic        bus_owner_i,
    output logic             address_valid_strobe_n_o,
    output logic             address_valid_strobe_oe_o,
    output logic [32:0]      bus_addr_n_o,
    output logic [4:0]       bus_req_n_o,
    output logic [1:0]       request_parity_lines_n_o,
    output logic             request_bus_oe_o,
    output logic             bus_error_reinit_n_o,
    output logic             bus_error_reinit_oe_o,
    output logic             new_request_stall_n_o,
    output logic             new_request_stall_oe_o,
    output logic [5:0]       breakpoint_monitor_outputs_n_o,
    output logic             parity_error_o,
    output logic             operating_o,
    output logic             bus_request_o,
    output logic             lock_active_o,
    output logic [7:0]       ioq_count_o
);
    // Pins from the bus pass two flops; all launch and sample is on this one clock.
    logic [1:0] strobe_s_r, reinit_s_r, stall_s_r, sense_s_r, owner_s_r;
    logic [32:0] addr_s1_r, addr_s2_r;
    logic [4:0]  req_s1_r, req_s2_r;
    logic [1:0]  par_s1_r, par_s2_r;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strobe_s_r <= 2'h3;
            reinit_s_r <= 2'h3;
            stall_s_r  <= 2'h3;
            sense_s_r  <= 2'h3;
            owner_s_r  <= 2'h0;
            addr_s1_r  <= 33'h1FFFFFFFF;
            addr_s2_r  <= 33'h1FFFFFFFF;
            req_s1_r   <= 5'h1F;
            req_s2_r   <= 5'h1F;
            par_s1_r   <= 2'h3;
            par_s2_r   <= 2'h3;
        end else begin
            strobe_s_r <= {strobe_s_r[0], address_valid_strobe_n_i};
            reinit_s_r <= {reinit_s_r[0], bus_error_reinit_n_i};
            stall_s_r  <= {stall_s_r[0], new_request_stall_n_i};
            sense_s_r  <= {sense_s_r[0], platform_sense_i};
            owner_s_r  <= {owner_s_r[0], bus_owner_i};
            addr_s1_r  <= bus_addr_n_i;
            addr_s2_r  <= addr_s1_r;
            req_s1_r   <= bus_req_n_i;
            req_s2_r   <= req_s1_r;
            par_s1_r   <= request_parity_lines_n_i;
            par_s2_r   <= par_s1_r;
        end
    end

    logic strobe_seen, reinit_seen, stall_seen, sense_ok, owner_ok;
    assign strobe_seen = ~strobe_s_r[1];
    assign reinit_seen = ~reinit_s_r[1] & cfg_init_observe_en_i;
    assign stall_seen  = ~stall_s_r[1];
    assign sense_ok    = sense_s_r[1];
    assign owner_ok    = owner_s_r[1];

    // Operation is refused while the platform sense reads low.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            operating_o <= 1'b0;
        end else begin
            operating_o <= sense_ok;
        end
    end

    // Generation and checking each have their own parity unit; the check uses subphase one coverage.
    parity_if gen_if ();
    parity_if chk_if ();
    req_parity_unit u_gen (.pif(gen_if.unit));
    req_parity_unit u_chk (.pif(chk_if.unit));
    assign gen_if.addr_n = ~issue_addr_i;
    assign gen_if.req_n  = ~issue_type_i;
    assign chk_if.addr_n = addr_s2_r;
    assign chk_if.req_n  = req_s2_r;

    // Any strobe seen on the bus, the agent's own or another agent's, starts the parity check of its request.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            parity_error_o <= 1'b0;
        end else begin
            parity_error_o <= strobe_seen && (par_s2_r != chk_if.sub1_par_n);
        end
    end

    // Arbitration and lock tracking are reset by reinit; the in-order queue is not.
    fsb_ctl_pkg::arb_state_type  arb_r;
    fsb_ctl_pkg::lock_state_type lock_r;
    logic [7:0] ioq_r;
    logic       start_issue;

    assign start_issue = (arb_r == fsb_ctl_pkg::ARB_OWNER) && issue_req_i && !stall_seen
                         && operating_o && !reinit_seen;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            arb_r <= fsb_ctl_pkg::ARB_IDLE;
        end else if (reinit_seen) begin
            arb_r <= fsb_ctl_pkg::ARB_IDLE;
        end else begin
            case (arb_r)
                fsb_ctl_pkg::ARB_IDLE: begin
                    // Pending queue entries make the agent ask again after reinit.
                    if (operating_o && (issue_req_i || ioq_r != 8'h00)) begin
                        arb_r <= fsb_ctl_pkg::ARB_REQUEST;
                    end
                end
                fsb_ctl_pkg::ARB_REQUEST: begin
                    if (owner_ok) begin
                        arb_r <= fsb_ctl_pkg::ARB_OWNER;
                    end
                end
                fsb_ctl_pkg::ARB_OWNER: begin
                    if (!owner_ok) begin
                        arb_r <= fsb_ctl_pkg::ARB_IDLE;
                    end
                end
                default: begin
                    arb_r <= fsb_ctl_pkg::ARB_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_r <= fsb_ctl_pkg::LOCK_IDLE;
        end else if (reinit_seen) begin
            lock_r <= fsb_ctl_pkg::LOCK_IDLE;
        end else begin
            case (lock_r)
                fsb_ctl_pkg::LOCK_IDLE: begin
                    if (start_issue && lock_req_i) begin
                        lock_r <= fsb_ctl_pkg::LOCK_HELD;
                    end
                end
                fsb_ctl_pkg::LOCK_HELD: begin
                    if (!lock_req_i) begin
                        lock_r <= fsb_ctl_pkg::LOCK_IDLE;
                    end
                end
                default: begin
                    lock_r <= fsb_ctl_pkg::LOCK_IDLE;
                end
            endcase
        end
    end

    // Queue depth is kept across reinit so outstanding entries can still complete.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ioq_r <= 8'h00;
        end else begin
            case ({start_issue && ioq_r < 8'(IOQ_DEPTH), complete_i && ioq_r != 8'h00})
                2'b10:   ioq_r <= ioq_r + 8'h01;
                2'b01:   ioq_r <= ioq_r - 8'h01;
                default: ioq_r <= ioq_r;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_request_o <= 1'b0;
            lock_active_o <= 1'b0;
            ioq_count_o   <= 8'h00;
        end else begin
            bus_request_o <= (arb_r != fsb_ctl_pkg::ARB_IDLE);
            lock_active_o <= (lock_r == fsb_ctl_pkg::LOCK_HELD);
            ioq_count_o   <= ioq_r;
        end
    end

    // Request launch: strobe, address, type and subphase one parity for one cycle.
    logic issue_ok;
    assign issue_ok = start_issue && ioq_r < 8'(IOQ_DEPTH);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            address_valid_strobe_n_o  <= 1'b1;
            address_valid_strobe_oe_o <= 1'b0;
            request_bus_oe_o          <= 1'b0;
            bus_addr_n_o              <= 33'h1FFFFFFFF;
            bus_req_n_o               <= 5'h1F;
            request_parity_lines_n_o  <= 2'h3;
        end else begin
            address_valid_strobe_n_o  <= ~issue_ok;
            address_valid_strobe_oe_o <= issue_ok;
            request_bus_oe_o          <= issue_ok;
            bus_addr_n_o              <= issue_ok ? gen_if.addr_n : 33'h1FFFFFFFF;
            bus_req_n_o               <= issue_ok ? gen_if.req_n : 5'h1F;
            request_parity_lines_n_o  <= issue_ok ? gen_if.sub1_par_n : 2'h3;
        end
    end

    // Reinit drive: a fault pulses the line low for a fixed hold when the driver is enabled.
    logic [7:0] init_cnt_r;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            init_cnt_r <= 8'h00;
        end else if (init_cnt_r != 8'h00) begin
            init_cnt_r <= init_cnt_r - 8'h01;
        end else if (bus_fault_i && cfg_init_drive_en_i) begin
            init_cnt_r <= `INIT_HOLD_CYCLES;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_error_reinit_n_o  <= 1'b1;
            bus_error_reinit_oe_o <= 1'b0;
        end else begin
            bus_error_reinit_n_o  <= ~(bus_fault_i && cfg_init_drive_en_i) && init_cnt_r <= 8'h01;
            bus_error_reinit_oe_o <= (bus_fault_i && cfg_init_drive_en_i) || init_cnt_r > 8'h01;
        end
    end

    // The agent stalls new requests while its own queue is full.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            new_request_stall_n_o  <= 1'b1;
            new_request_stall_oe_o <= 1'b0;
        end else begin
            new_request_stall_n_o  <= ~(ioq_r >= 8'(IOQ_DEPTH));
            new_request_stall_oe_o <= (ioq_r >= 8'(IOQ_DEPTH));
        end
    end

    // Monitor outputs are active low; line four also reports probe ready.
    logic [5:0] bpm_src;
    always_comb begin
        bpm_src = monitor_event_i;
        bpm_src[`BPM_PROBE_READY] = monitor_event_i[`BPM_PROBE_READY] | debug_ready_i;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            breakpoint_monitor_outputs_n_o <= 6'h3F;
        end else begin
            breakpoint_monitor_outputs_n_o <= ~bpm_src;
        end
    end

    AST_NO_ISSUE_IN_STALL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        stall_seen |=> address_valid_strobe_n_o) else $error("Request issued during stall.");
    AST_SENSE_LOW: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !sense_ok |=> !operating_o ##1 address_valid_strobe_n_o) else $error("Operating with sense low.");
    AST_REINIT_ARB: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        reinit_seen |=> arb_r == fsb_ctl_pkg::ARB_IDLE && lock_r == fsb_ctl_pkg::LOCK_IDLE)
        else $error("Arbitration not reset by reinit.");
    AST_IOQ_KEPT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        reinit_seen && !complete_i |=> ioq_r == $past(ioq_r)) else $error("Queue lost on reinit.");
    AST_REINIT_DRIVE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        bus_fault_i && cfg_init_drive_en_i && init_cnt_r == 8'h00 |=> !bus_error_reinit_n_o [*4])
        else $error("Reinit not held low.");
    AST_PARITY_OUT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !address_valid_strobe_n_o |-> request_parity_lines_n_o[0] == ^{1'b1, ~bus_addr_n_o[32:21]})
        else $error("Bad parity driven.");
    AST_IDLE_PARITY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        address_valid_strobe_n_o |-> request_parity_lines_n_o == 2'h3) else $error("Idle parity low.");
    AST_PROBE_READY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        debug_ready_i |=> !breakpoint_monitor_outputs_n_o[4]) else $error("Probe ready missing.");
    AST_REARB: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        $fell(reinit_seen) && operating_o && ioq_r != 8'h00 && !reinit_seen |=> ##[0:1] bus_request_o)
        else $error("No re-arbitration after reinit.");
endmodule : fsb_ctl

// ===== design/req_parity_unit.sv
// Combinational parity generator for both request subphases.
`timescale 1ns/1ps
`include "fsb_ctl_map.svh"
module req_parity_unit (
    parity_if.unit pif
);
    logic hi_group_n;
    logic lo_group_n;

    // An odd count of low lines gives a low parity line; all high gives high.
    always_comb begin
        hi_group_n = ~^(~pif.addr_n[32:21]);
        lo_group_n = ~^({~pif.addr_n[20:0], ~pif.req_n});
    end

    always_comb begin
        pif.sub1_par_n = {lo_group_n, hi_group_n};
        pif.sub2_par_n = {hi_group_n, lo_group_n};
    end
endmodule : req_parity_unit

// ===== inc/fsb_ctl_map.svh
// Header holding the bit positions, widths and timing figures of the bus control block.
`ifndef FSB_CTL_MAP_SVH
`define FSB_CTL_MAP_SVH

`define ADDR_HI_MSB       35
`define ADDR_HI_LSB       24
`define ADDR_LO_MSB       23
`define ADDR_LO_LSB       3
`define REQ_TYPE_W        5
`define BPM_W             6
`define BPM_PROBE_READY   4
`define INIT_HOLD_CYCLES  8'h04
`define INIT_WAIT_CYCLES  8'h02

`endif

// ===== inc/fsb_ctl_pkg.sv
// Package holding the types of the bus control block.
package fsb_ctl_pkg;
    typedef enum logic [1:0] {
        ARB_IDLE,
        ARB_REQUEST,
        ARB_OWNER
    } arb_state_type;

    typedef enum logic [1:0] {
        LOCK_IDLE,
        LOCK_HELD
    } lock_state_type;
endpackage : fsb_ctl_pkg

// ===== inc/parity_if.sv
// Interface carrying a request and its parity between the control block and the parity unit.
`timescale 1ns/1ps
interface parity_if;
    logic [32:0] addr_n;
    logic [4:0]  req_n;
    logic [1:0]  sub1_par_n;
    logic [1:0]  sub2_par_n;

    modport master (
        output addr_n,
        output req_n,
        input  sub1_par_n,
        input  sub2_par_n
    );
    modport unit (
        input  addr_n,
        input  req_n,
        output sub1_par_n,
        output sub2_par_n
    );
endinterface : parity_if

// ===== testbench/fsb_ctl_bench.sv
// Self-checking bench of the bus agent control block facing a far-side agent model.
`timescale 1ns/1ps
module fsb_ctl_bench;
    localparam int DEPTH = 4;
    logic        clk, rst_n, sense, fault, issue, lock_req, complete, dbg_rdy;
    logic        stb_n, stb_oe, req_oe, ri_n, ri_oe, st_n, st_oe, perr, oper, breq, lock;
    logic        f_stb_n, f_st_n, f_ri_n;
    logic        obs_en, drv_en;
    logic [32:0] iaddr, d_addr_n, f_addr_n;
    logic [4:0]  itype, d_req_n, f_req_n;
    logic [1:0]  d_par_n, f_par_n;
    logic [5:0]  mon, bpm_n;
    logic [7:0]  in_order_queue;
    int          errors = 0;
    int          num_checks = 0;

    fsb_ctl #(.IOQ_DEPTH(DEPTH)) dut (
        .core_clk_i                     (clk),
        .rst_n_i                        (rst_n),
        .cfg_init_drive_en_i            (drv_en),
        .cfg_init_observe_en_i          (obs_en),
        .platform_sense_i               (sense),
        .bus_fault_i                    (fault),
        .issue_req_i                    (issue),
        .issue_addr_i                   (iaddr),
        .issue_type_i                   (itype),
        .lock_req_i                     (lock_req),
        .complete_i                     (complete),
        .monitor_event_i                (mon),
        .debug_ready_i                  (dbg_rdy),
        // Driven request lines carry the driver's value; otherwise the far agent's.
        .address_valid_strobe_n_i       (stb_oe ? stb_n : f_stb_n),
        .bus_addr_n_i                   (req_oe ? d_addr_n : f_addr_n),
        .bus_req_n_i                    (req_oe ? d_req_n : f_req_n),
        .request_parity_lines_n_i       (req_oe ? d_par_n : f_par_n),
        // Reinit and stall are wired so that any agent pulling low wins.
        .bus_error_reinit_n_i           ((ri_n | ~ri_oe) & f_ri_n),
        .new_request_stall_n_i          ((st_n | ~st_oe) & f_st_n),
        .bus_owner_i                    (1'b1),
        .address_valid_strobe_n_o       (stb_n),
        .address_valid_strobe_oe_o      (stb_oe),
        .bus_addr_n_o                   (d_addr_n),
        .bus_req_n_o                    (d_req_n),
        .request_parity_lines_n_o       (d_par_n),
        .request_bus_oe_o               (req_oe),
        .bus_error_reinit_n_o           (ri_n),
        .bus_error_reinit_oe_o          (ri_oe),
        .new_request_stall_n_o          (st_n),
        .new_request_stall_oe_o         (st_oe),
        .breakpoint_monitor_outputs_n_o (bpm_n),
        .parity_error_o                 (perr),
        .operating_o                    (oper),
        .bus_request_o                  (breq),
        .lock_active_o                  (lock),
        .ioq_count_o                    (in_order_queue)
    );

    fsb_far_agent far (
        .core_clk_i (clk),
        .strobe_n_o (f_stb_n),
        .addr_n_o   (f_addr_n),
        .req_n_o    (f_req_n),
        .par_n_o    (f_par_n),
        .stall_n_o  (f_st_n),
        .reinit_n_o (f_ri_n)
    );

    task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic retire(input int n);
        repeat (n) begin
            complete = 1'b1;
            @(negedge clk);
            complete = 1'b0;
            @(negedge clk);
        end
    endtask : retire

    // Requests hold until the first strobe, since the grant takes a few cycles to settle.
    task automatic arbitrate();
        int k;
        k = 0;
        issue = 1'b1;
        while (stb_n !== 1'b0 && k < 20) begin
            @(negedge clk);
            k++;
        end
        issue = 1'b0;
        chk("granted", 33'(k < 20), 33'h1);
        // The queue count shows one cycle after the strobe, so wait before retiring.
        @(negedge clk);
        for (k = 0; k < 8 && in_order_queue !== 8'h00; k++) retire(1);
    endtask : arbitrate

    // One-cycle request; counts strobes and loops the own request back through the checker.
    task automatic issue_chk(input logic [32:0] a, input logic [4:0] t, input logic taken);
        int n;
        int pe;
        n = 0;
        pe = 0;
        iaddr = a;
        itype = t;
        issue = 1'b1;
        @(negedge clk);
        issue = 1'b0;
        repeat (8) begin
            if (stb_n === 1'b0) begin
                n++;
                chk("addr", d_addr_n, ~a);
                chk("type", 33'(d_req_n), {28'h0, ~t});
                chk("enables", 33'({stb_oe, req_oe}), 33'h3);
                chk("parity", 33'(d_par_n), 33'(far.par_of(~a, ~t)));
            end
            pe += int'(perr === 1'b1);
            @(negedge clk);
        end
        chk("strobes", 33'(n), 33'(taken));
        chk("own parity", 33'(pe), 33'h0);
    endtask : issue_chk

    task automatic t_parity();
        logic [37:0] tbl [7];
        tbl = '{38'h0, 38'h3F_FFFF_FFFF, 38'h20_0000_0000, 38'h0_0400_0000,
                38'h0_0200_0000, 38'h0_0000_0001, 38'h15_A5C3_0F2D};
        foreach (tbl[i]) begin
            issue_chk(tbl[i][37:5], tbl[i][4:0], 1'b1);
            retire(1);
        end
        $display("test parity done");
    endtask : t_parity

    task automatic t_stall();
        repeat (DEPTH) issue_chk(33'h0_1234_5678, 5'h02, 1'b1);
        chk("full", 33'(in_order_queue), 33'(DEPTH));
        chk("stall out", 33'({st_n, st_oe}), 33'h1);
        issue_chk(33'h0_0000_0008, 5'h01, 1'b0);
        retire(1);
        repeat (4) @(negedge clk);
        issue_chk(33'h0_0000_0010, 5'h03, 1'b1);
        retire(DEPTH);
        far.lines(1'b0, 1'b1);
        repeat (3) @(negedge clk);
        issue_chk(33'h0_0000_0018, 5'h04, 1'b0);
        far.lines(1'b1, 1'b1);
        repeat (3) @(negedge clk);
        issue_chk(33'h0_0000_0020, 5'h05, 1'b1);
        retire(1);
        $display("test stall done");
    endtask : t_stall

    task automatic t_inbound();
        int pe;
        for (int b = 0; b < 2; b++) begin
            pe = 0;
            far.send(33'h0_ABCD_1357 ^ 33'(b), 5'(b + 6), 1'(b));
            repeat (6) begin
                pe += int'(perr === 1'b1);
                @(negedge clk);
            end
            chk("inbound parity", 33'(pe), 33'(b));
        end
        $display("test inbound done");
    endtask : t_inbound

    task automatic t_reinit();
        int hold;
        int dropped;
        hold = 0;
        dropped = 0;
        lock_req = 1'b1;
        issue_chk(33'h0_0000_0040, 5'h06, 1'b1);
        chk("lock", 33'(lock), 33'h1);
        fault = 1'b1;
        @(negedge clk);
        fault = 1'b0;
        repeat (12) begin
            hold += int'(ri_oe === 1'b1 && ri_n === 1'b0);
            dropped |= int'(lock === 1'b0);
            @(negedge clk);
        end
        chk("reinit driven", 33'(hold > 0 && hold < 8), 33'h1);
        chk("lock reset", 33'(dropped), 33'h1);
        chk("queue kept", 33'(in_order_queue), 33'h1);
        chk("rearb", 33'(breq), 33'h1);
        lock_req = 1'b0;
        arbitrate();
        $display("test reinit done");
    endtask : t_reinit

    task automatic t_monitor();
        for (int i = 0; i < 6; i++) begin
            mon = 6'h01 << i;
            repeat (3) @(negedge clk);
            chk("monitor", 33'(bpm_n), {27'h0, ~mon});
        end
        mon = 6'h00;
        dbg_rdy = 1'b1;
        repeat (3) @(negedge clk);
        chk("probe ready", 33'(bpm_n), 33'h2F);
        dbg_rdy = 1'b0;
        $display("test monitor done");
    endtask : t_monitor

    // Observation and drive off: a reinit from the far side is the central agent's business.
    task automatic t_no_observe();
        int hold;
        hold = 0;
        obs_en = 1'b0;
        drv_en = 1'b0;
        lock_req = 1'b1;
        issue_chk(33'h0_0000_0100, 5'h08, 1'b1);
        fault = 1'b1;
        far.lines(1'b1, 1'b0);
        fault = 1'b0;
        repeat (6) begin
            hold += int'(ri_oe === 1'b1);
            @(negedge clk);
        end
        chk("no drive", 33'(hold), 33'h0);
        chk("lock kept", 33'(lock), 33'h1);
        chk("arb kept", 33'(breq), 33'h1);
        far.lines(1'b1, 1'b1);
        // The synchroniser still holds the low level for two edges after release.
        repeat (3) @(negedge clk);
        lock_req = 1'b0;
        obs_en = 1'b1;
        drv_en = 1'b1;
        retire(1);
        $display("test no observe done");
    endtask : t_no_observe

    task automatic t_sense();
        sense = 1'b0;
        repeat (5) @(negedge clk);
        chk("stopped", 33'(oper), 33'h0);
        issue_chk(33'h0_0000_0080, 5'h07, 1'b0);
        sense = 1'b1;
        repeat (5) @(negedge clk);
        chk("running", 33'(oper), 33'h1);
        $display("test sense done");
    endtask : t_sense

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Whole run needs well under a thousand cycles; this cuts a hang short.
    initial begin
        #200000;
        errors++;
        close_out();
    end

    initial begin
        {rst_n, sense, fault, issue, lock_req, complete, dbg_rdy} = 7'h20;
        obs_en = 1'b1;
        drv_en = 1'b1;
        iaddr = 33'h0;
        itype = 5'h00;
        mon = 6'h00;
        repeat (12) @(negedge clk);
        chk("reset", 33'({stb_n, ri_n, st_n, bpm_n, stb_oe, req_oe, ri_oe, st_oe, oper, in_order_queue}), 33'h3F_E000);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk("operating", 33'(oper), 33'h1);
        arbitrate();
        t_parity();
        t_stall();
        t_inbound();
        t_reinit();
        t_no_observe();
        t_monitor();
        t_sense();
        close_out();
    end
endmodule : fsb_ctl_bench

// ===== testbench/fsb_far_agent.sv
// Far-side bus agent model: sends requests with parity and drives the stall and reinit lines.
`timescale 1ns/1ps
module fsb_far_agent (
    input  wire logic        core_clk_i,
    output logic             strobe_n_o = 1'b1,
    output logic [32:0]      addr_n_o   = 33'h1_FFFF_FFFF,
    output logic [4:0]       req_n_o    = 5'h1F,
    output logic [1:0]       par_n_o    = 2'h3,
    output logic             stall_n_o  = 1'b1,
    output logic             reinit_n_o = 1'b1
);
    // Subphase one grouping; a line is low only for an odd count of low covered lines.
    function automatic logic [1:0] par_of(input logic [32:0] a_n, input logic [4:0] r_n);
        par_of[0] = ~(^(~a_n[32:21]));
        par_of[1] = ~(^{~a_n[20:0], ~r_n});
    endfunction : par_of

    // Lines move just after the falling edge so the block samples them settled.
    task automatic send(input logic [32:0] a, input logic [4:0] t, input logic bad);
        @(negedge core_clk_i);
        addr_n_o   = ~a;
        req_n_o    = ~t;
        par_n_o    = par_of(~a, ~t) ^ {1'b0, bad};
        strobe_n_o = 1'b0;
        @(negedge core_clk_i);
        // Released lines go back high, as the termination pulls them up.
        strobe_n_o = 1'b1;
        addr_n_o   = 33'h1_FFFF_FFFF;
        req_n_o    = 5'h1F;
        par_n_o    = 2'h3;
    endtask : send

    task automatic lines(input logic stall_n, input logic reinit_n);
        @(negedge core_clk_i);
        stall_n_o  = stall_n;
        reinit_n_o = reinit_n;
    endtask : lines
endmodule : fsb_far_agent
